// ==== rtl/bit_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rate_divider.sv ====
// free-running half bit tick generator for master mode
`timescale 1ns/1ps
`default_nettype none

module rate_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [1:0] rate,
  // one-cycle pulse every half bit time
  output logic tick
);

  logic [6:0] count;
  logic [6:0] next_count;
  logic next_tick;
  logic [6:0] half;

  // next count and tick
  always_comb
  begin
    case (rate)
      spi_core_pkg::RATE_DIV2: half = spi_core_pkg::HALF_BIT_DIV2;
      spi_core_pkg::RATE_DIV8: half = spi_core_pkg::HALF_BIT_DIV8;
      spi_core_pkg::RATE_DIV32: half = spi_core_pkg::HALF_BIT_DIV32;
      default: half = spi_core_pkg::HALF_BIT_DIV128;
    endcase
    next_count = 7'h00;
    next_tick = 1'b0;
    if (run)
    begin
      if (count >= half - 7'h01)
        next_tick = 1'b1;
      else
        next_count = count + 7'h01;
    end
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/spi_core_pkg.sv ====
// constants and types shared by the serial port core
package spi_core_pkg;

  // half bit time in bus cycles for each rate select setting
  localparam logic [6:0] HALF_BIT_DIV2 = 7'h01;
  localparam logic [6:0] HALF_BIT_DIV8 = 7'h04;
  localparam logic [6:0] HALF_BIT_DIV32 = 7'h10;
  localparam logic [6:0] HALF_BIT_DIV128 = 7'h40;

  // rate select encodings
  localparam logic [1:0] RATE_DIV2 = 2'h0;
  localparam logic [1:0] RATE_DIV8 = 2'h1;
  localparam logic [1:0] RATE_DIV32 = 2'h2;

  // index of the last serial clock edge of a byte (16 edges)
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // reset values
  localparam logic TX_EMPTY_RESET = 1'h1;
  localparam logic RX_FULL_RESET = 1'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b10
  } state_type;

endpackage

// ==== rtl/spi_master_slave_core.sv ====
// byte-wide full-duplex serial port core, master and slave
//
// Contract
// - master bit set: master, else slave
// - only master starts, on data write
// - empty shifter loads at once, sets tx empty
// - rate bits set master clock speed
// - master done: rx full and data together
// - rx full cleared by status then data read
// - any data write clears tx empty
// - slave full byte: load data, set full
// - slave accepts any clock, rate ignored
// - slave byte written before start, else leftover shifter bits sent
// - write during transfer waits in buffer
// - polarity bit chooses clock idle level
// - slave drives MISO only while selected
// - phase 0: select fall starts, MSB driven
// - phase 1: first clock edge starts
// - no buffer load once transfer begun
// - bit time 2, 8, 32, 128 cycles
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control bits
  input wire logic port_enable_bit,
  input wire logic master_select_bit,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic rate_select_hi,
  input wire logic rate_select_lo,
  // software access strobes and data
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic status_read,
  input wire logic data_read,
  output logic [7:0] rx_data,
  // status flags
  output logic tx_empty_flag,
  output logic rx_full_flag,
  // serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  // master out slave in pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  // master in slave out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  // slave select input
  input wire logic slave_select_n
);

  spi_core_pkg::state_type state;
  spi_core_pkg::state_type next_state;
  logic [3:0] sync_in;
  logic [3:0] sync_pins;
  logic sck_sync;
  logic ss_n_sync;
  logic mosi_sync;
  logic miso_sync;
  logic sck_prev;
  logic ss_n_prev;
  logic tick;
  logic run_master;
  logic slave_on;
  logic [7:0] tx_buf;
  logic [7:0] next_tx_buf;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] rx_shift;
  logic [7:0] next_rx_shift;
  logic [7:0] next_rx_data;
  logic [3:0] edge_cnt;
  logic [3:0] next_edge_cnt;
  logic loaded;
  logic next_loaded;
  logic clear_armed;
  logic next_clear_armed;
  logic next_tx_empty;
  logic next_rx_full;
  logic next_sck_out;
  logic next_sck_oe_n;
  logic next_mosi_oe_n;
  logic next_miso_oe_n;
  logic sck_edge;
  logic ss_fall;
  logic data_in;
  logic ev;
  logic leading;
  logic do_sample;
  logic do_shift;
  logic [1:0] samp_pipe;
  logic [1:0] next_samp_pipe;
  logic [1:0] done_pipe;
  logic [1:0] next_done_pipe;

  // pin inputs pass two flip-flops before use
  assign sync_in = {serial_clock_pin_in, slave_select_n, mosi_in, miso_in};

  bit_sync #(
    .WIDTH(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(sync_in),
    .sync_out(sync_pins)
  );

  assign sck_sync = sync_pins[3];
  assign ss_n_sync = sync_pins[2];
  assign mosi_sync = sync_pins[1];
  assign miso_sync = sync_pins[0];

  // mode decode
  assign run_master = port_enable_bit & master_select_bit;
  assign slave_on = port_enable_bit & ~master_select_bit;

  // master clock divider runs only when the master is enabled
  rate_divider u_rate (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(run_master),
    .rate({rate_select_hi, rate_select_lo}),
    .tick(tick)
  );

  // slave clock edges come from the pin, any rate up to the sampling limit
  assign sck_edge = sck_sync ^ sck_prev;
  assign ss_fall = ss_n_prev & ~ss_n_sync;
  assign data_in = master_select_bit ? miso_sync : mosi_sync;
  assign ev = master_select_bit ? tick : sck_edge;
  assign leading = ~edge_cnt[0];
  // phase 0 samples on leading edges, phase 1 on trailing edges
  assign do_sample = clock_phase ? ~leading : leading;
  assign do_shift = clock_phase ? (leading && edge_cnt != 4'h0) : ~leading;

  // next state of sequencer, buffers and flags
  always_comb
  begin
    next_state = state;
    next_tx_buf = tx_buf;
    next_shreg = shreg;
    next_rx_shift = rx_shift;
    next_rx_data = rx_data;
    next_edge_cnt = edge_cnt;
    next_loaded = loaded;
    next_clear_armed = clear_armed;
    next_tx_empty = tx_empty_flag;
    next_rx_full = rx_full_flag;
    next_sck_out = serial_clock_pin_out;
    next_samp_pipe = {samp_pipe[0], 1'b0};
    next_done_pipe = {done_pipe[0], 1'b0};

    // two-step clear of the receive flag
    if (status_read && rx_full_flag)
      next_clear_armed = 1'b1;
    if (data_read && clear_armed)
    begin
      next_rx_full = 1'b0;
      next_clear_armed = 1'b0;
    end

    // master capture lags the edge by the two synchroniser stages
    if (samp_pipe[1])
      next_rx_shift = {rx_shift[6:0], miso_sync};
    if (done_pipe[1])
    begin
      next_rx_data = next_rx_shift;
      next_rx_full = 1'b1;
    end

    case (state)
      spi_core_pkg::ST_IDLE:
      begin
        next_sck_out = clock_polarity;
        next_edge_cnt = 4'h0;
        // buffer moves to the shifter only between transfers
        if (!tx_empty_flag)
        begin
          next_shreg = tx_buf;
          next_tx_empty = 1'b1;
          next_loaded = 1'b1;
        end
        if (run_master)
        begin
          // a loaded byte starts on the next divider tick
          if (loaded && tick)
          begin
            next_loaded = 1'b0;
            next_state = clock_phase ? spi_core_pkg::ST_SHIFT
                                     : spi_core_pkg::ST_SETUP;
          end
        end
        else if (slave_on && !ss_n_sync)
        begin
          next_loaded = 1'b0;
          if (!clock_phase && ss_fall)
            next_state = spi_core_pkg::ST_SHIFT;
          else if (clock_phase && sck_edge)
          begin
            next_state = spi_core_pkg::ST_SHIFT;
            next_edge_cnt = 4'h1;
          end
        end
      end
      spi_core_pkg::ST_SETUP:
      begin
        // phase 0 master: clock stays idle for the first half bit
        if (tick)
          next_state = spi_core_pkg::ST_SHIFT;
      end
      spi_core_pkg::ST_SHIFT:
      begin
        if (ev)
        begin
          if (master_select_bit)
            next_sck_out = ~serial_clock_pin_out;
          if (do_sample && master_select_bit)
            next_samp_pipe[0] = 1'b1;
          else if (do_sample)
            next_rx_shift = {rx_shift[6:0], data_in};
          if (do_shift)
            next_shreg = {shreg[6:0], 1'b0};
          next_edge_cnt = edge_cnt + 4'h1;
          if (edge_cnt == spi_core_pkg::LAST_EDGE)
          begin
            next_state = spi_core_pkg::ST_IDLE;
            if (master_select_bit)
              next_done_pipe[0] = 1'b1;
            else
            begin
              next_rx_data = next_rx_shift;
              next_rx_full = 1'b1;
            end
          end
        end
        // a slave deselected mid-byte drops the transfer
        if (!master_select_bit && ss_n_sync)
          next_state = spi_core_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = spi_core_pkg::ST_IDLE;
      end
    endcase

    // a write always refills the buffer and clears the empty flag
    if (tx_write)
    begin
      next_tx_buf = tx_data;
      next_tx_empty = 1'b0;
    end

    // disabling the port ends any transfer
    if (!port_enable_bit)
    begin
      next_state = spi_core_pkg::ST_IDLE;
      next_loaded = 1'b0;
      next_sck_out = clock_polarity;
    end
  end

  // pin drive enables, low while driving
  always_comb
  begin
    next_sck_oe_n = ~run_master;
    next_mosi_oe_n = ~run_master;
    next_miso_oe_n = ~(slave_on & ~ss_n_sync);
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= spi_core_pkg::ST_IDLE;
      tx_buf <= spi_core_pkg::DATA_RESET;
      shreg <= spi_core_pkg::DATA_RESET;
      rx_shift <= spi_core_pkg::DATA_RESET;
      rx_data <= spi_core_pkg::DATA_RESET;
      edge_cnt <= 4'h0;
      loaded <= 1'b0;
      samp_pipe <= 2'h0;
      done_pipe <= 2'h0;
      clear_armed <= 1'b0;
      tx_empty_flag <= spi_core_pkg::TX_EMPTY_RESET;
      rx_full_flag <= spi_core_pkg::RX_FULL_RESET;
      sck_prev <= 1'b0;
      ss_n_prev <= 1'b1;
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      mosi_out <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      tx_buf <= next_tx_buf;
      shreg <= next_shreg;
      rx_shift <= next_rx_shift;
      rx_data <= next_rx_data;
      edge_cnt <= next_edge_cnt;
      loaded <= next_loaded;
      samp_pipe <= next_samp_pipe;
      done_pipe <= next_done_pipe;
      clear_armed <= next_clear_armed;
      tx_empty_flag <= next_tx_empty;
      rx_full_flag <= next_rx_full;
      sck_prev <= sck_sync;
      ss_n_prev <= ss_n_sync;
      serial_clock_pin_out <= next_sck_out;
      serial_clock_pin_oe_n <= next_sck_oe_n;
      mosi_out <= next_shreg[7];
      mosi_oe_n <= next_mosi_oe_n;
      miso_out <= next_shreg[7];
      miso_oe_n <= next_miso_oe_n;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/spi_core_properties.sv ====
// assertion checker for the serial port core pins and flags
`timescale 1ns/1ps
`default_nettype none
module spi_core_properties (
  // clock, reset and controls
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic port_enable_bit,
  input wire logic master_select_bit,
  input wire logic clock_polarity,
  input wire logic tx_write,
  input wire logic status_read,
  input wire logic data_read,
  input wire logic slave_select_n,
  // outputs watched
  input wire logic [7:0] rx_data,
  input wire logic tx_empty_flag,
  input wire logic rx_full_flag,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // status read finding the flag set, then a data read
  sequence s_clear;
    status_read && rx_full_flag ##[1:40] data_read;
  endsequence
  property p_tx_clear;
    tx_write |=> !tx_empty_flag;
  endproperty
  property p_rx_clear;
    s_clear |=> !rx_full_flag;
  endproperty
  property p_rx_hold;
    rx_full_flag && !data_read |=> rx_full_flag;
  endproperty
  property p_rx_together;
    $changed(rx_data) |-> rx_full_flag;
  endproperty
  property p_miso_release;
    slave_select_n [*5] |-> miso_oe_n;
  endproperty
  property p_master_pins;
    (port_enable_bit && master_select_bit) [*3] |-> !serial_clock_pin_oe_n && !mosi_oe_n && miso_oe_n;
  endproperty
  property p_slave_pins;
    (!master_select_bit) [*3] |-> serial_clock_pin_oe_n && mosi_oe_n;
  endproperty
  property p_idle_level;
    (!port_enable_bit) [*3] |-> serial_clock_pin_out == clock_polarity;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("tx empty not cleared by write");
  a_rx_clear: assert property (p_rx_clear)
    else $error("rx full not cleared");
  a_rx_hold: assert property (p_rx_hold)
    else $error("rx full dropped without data read");
  a_rx_together: assert property (p_rx_together)
    else $error("rx data changed without rx full");
  a_miso_release: assert property (p_miso_release)
    else $error("miso driven while deselected");
  a_master_pins: assert property (p_master_pins)
    else $error("master pin directions wrong");
  a_slave_pins: assert property (p_slave_pins)
    else $error("slave pin directions wrong");
  a_idle_level: assert property (p_idle_level)
    else $error("clock not at idle level");
endmodule
`default_nettype wire

// ==== testbench/spi_far_end.sv ====
// far end model: slave for a master core, master for a slave core
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  // clock and format
  input wire logic sys_clk,
  input wire logic cpol,
  input wire logic cpha,
  // lines from a master core
  input wire logic sck_in,
  input wire logic mosi_in,
  output logic miso,
  // lines toward a slave core
  input wire logic miso_in,
  output logic sck,
  output logic mosi,
  output logic ss_n
);
  logic [7:0] sr = 8'h00;
  logic [7:0] got = 8'h00;
  int edges = 16;
  initial
  begin
    mosi = 1'h0;
    sck = 1'h0;
    ss_n = 1'h1;
  end
  // clock rests at idle level while deselected
  always @(cpol)
    if (ss_n) sck = cpol;
  // slave role: capture on sample edges, shift on the others, msb first
  always @(sck_in)
    if (edges < 16)
    begin
      if (edges[0] == cpha) got = {got[6:0], mosi_in};
      else if (edges > 0) sr = {sr[6:0], ~sr[7]};
      edges = edges + 1;
    end
  assign miso = (edges < 16) ? sr[7] : ~sr[7];
  task automatic load(input logic [7:0] b);
    sr = b;
    edges = 0;
  endtask
  // master role: one byte, half bit of 6 clocks, select low throughout
  task automatic xfer(input logic [7:0] b, input logic hold);
    ss_n = 1'h0;
    repeat (6) @(negedge sys_clk);
    for (int i = 7; i >= 0; i--)
    begin
      if (cpha) sck = ~cpol;
      mosi = b[i];
      repeat (6) @(negedge sys_clk);
      sck = ~sck;
      got = {got[6:0], miso_in};
      repeat (6) @(negedge sys_clk);
      if (!cpha) sck = cpol;
    end
    mosi = ~mosi;
    if (!hold) ss_n = 1'h1;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_spi_master_slave_core.sv ====
// self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_core;
  typedef struct {logic [1:0] rate; logic pol; logic ph; logic [7:0] tx; logic [7:0] rx;} row_type;
  row_type rows [4] = '{'{2'h0, 1'h0, 1'h0, 8'hA5, 8'h3C}, '{2'h1, 1'h0, 1'h1, 8'h81, 8'h7E},
    '{2'h2, 1'h1, 1'h0, 8'h5A, 8'hC3}, '{2'h3, 1'h1, 1'h1, 8'h0F, 8'hF0}};
  logic sys_clk = 1'h0, rst = 1'h1, en = 1'h0, mst = 1'h0, cpol = 1'h0, cpha = 1'h0;
  logic rhi = 1'h0, rlo = 1'h0, wr = 1'h0, srd = 1'h0, drd = 1'h0;
  logic [7:0] txd = 8'h00;
  logic [7:0] rxd;
  logic txe, rxf, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  wire logic sck_far, mosi_far, miso_far, ss_n;
  // resolve each pin from whoever drives it
  wire logic sck_l = sck_oe_n ? sck_far : sck_o;
  wire logic mosi_l = mosi_oe_n ? mosi_far : mosi_o;
  wire logic miso_l = miso_oe_n ? miso_far : miso_o;
  int err_total = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  spi_master_slave_core dut (.sys_clk, .rst, .port_enable_bit(en), .master_select_bit(mst),
    .clock_polarity(cpol), .clock_phase(cpha), .rate_select_hi(rhi), .rate_select_lo(rlo),
    .tx_write(wr), .tx_data(txd), .status_read(srd), .data_read(drd), .rx_data(rxd),
    .tx_empty_flag(txe), .rx_full_flag(rxf), .serial_clock_pin_in(sck_l),
    .serial_clock_pin_out(sck_o), .serial_clock_pin_oe_n(sck_oe_n), .mosi_in(mosi_l),
    .mosi_out(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_in(miso_l), .miso_out(miso_o),
    .miso_oe_n(miso_oe_n), .slave_select_n(ss_n));
  spi_far_end far (.sys_clk, .cpol, .cpha, .sck_in(sck_l), .mosi_in(mosi_l), .miso(miso_far),
    .miso_in(miso_l), .sck(sck_far), .mosi(mosi_far), .ss_n);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic write(input logic [7:0] b);
    txd = b;
    wr = 1'h1;
    @(negedge sys_clk);
    wr = 1'h0;
  endtask
  task automatic clear_rx;
    srd = 1'h1;
    @(negedge sys_clk);
    srd = 1'h0;
    drd = 1'h1;
    @(negedge sys_clk);
    drd = 1'h0;
    @(negedge sys_clk);
  endtask
  // reconfigure while disabled, then enable
  task automatic setup(input logic m, input logic p, input logic h);
    en = 1'h0;
    @(negedge sys_clk);
    {mst, cpol, cpha} = {m, p, h};
    repeat (4) @(negedge sys_clk);
    en = 1'h1;
    @(negedge sys_clk);
  endtask
  // cut a hang well past the longest expected run
  initial
  begin
    #2000000;
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    int n;
    int b;
    repeat (10) @(negedge sys_clk);
    rst = 1'h0;
    check(txe, 8'h01, "tx_empty reset");
    check(rxf, 8'h00, "rx_full reset");
    check({sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07, "pins released");
    // master transfers over every rate and clock format
    foreach (rows[i])
    begin
      {rhi, rlo} = rows[i].rate;
      setup(1'h1, rows[i].pol, rows[i].ph);
      far.load(rows[i].rx);
      write(rows[i].tx);
      check(txe, 8'h00, "tx_empty after write");
      @(negedge sys_clk);
      check(txe, 8'h01, "tx_empty after load");
      for (n = 0; n < 5000 && rxf !== 1'h1; n++) @(negedge sys_clk);
      b = 2 << (2 * rows[i].rate);
      check(8'(n >= 8 * b - 4 && n <= 9 * b + 4), 8'h01, "transfer length");
      check(rxd, rows[i].rx, "master rx_data");
      check(far.got, rows[i].tx, "mosi byte");
      clear_rx;
      check(rxf, 8'h00, "rx_full cleared");
    end
    // slave, phase 0: a data read alone keeps the flag
    setup(1'h0, 1'h0, 1'h0);
    write(8'hC6);
    far.xfer(8'h39, 1'h0);
    check(rxd, 8'h39, "slave rx_data");
    check(far.got, 8'hC6, "miso byte");
    drd = 1'h1;
    @(negedge sys_clk);
    drd = 1'h0;
    @(negedge sys_clk);
    check(rxf, 8'h01, "rx_full after lone data read");
    clear_rx;
    // slave, phase 1: write during a transfer waits for its end
    setup(1'h0, 1'h1, 1'h1);
    write(8'hA3);
    fork
      far.xfer(8'h5C, 1'h1);
      begin
        repeat (30) @(negedge sys_clk);
        write(8'h4B);
        @(negedge sys_clk);
        check(txe, 8'h00, "buffer held mid transfer");
      end
    join
    check(far.got, 8'hA3, "first slave byte");
    clear_rx;
    far.xfer(8'hE1, 1'h0);
    check(far.got, 8'h4B, "queued slave byte");
    check(rxd, 8'hE1, "second slave rx_data");
    tally_and_finish;
  end
endmodule
bind spi_master_slave_core spi_core_properties chk (.sys_clk, .rst, .port_enable_bit,
  .master_select_bit, .clock_polarity, .tx_write, .status_read, .data_read, .slave_select_n,
  .rx_data, .tx_empty_flag, .rx_full_flag, .serial_clock_pin_out, .serial_clock_pin_oe_n,
  .mosi_oe_n, .miso_oe_n);
`default_nettype wire
